// file: src/dmcsr_top.sv
// Purpose: Decoder and runtime control-register bank of a DSP companion memory.
// Assumes: Host pins are asynchronous to mclk_i and are filtered here.
// Notes:   Writes take effect on the rising edge of the filtered write strobe.

// Function
// - Control block selected for 0x00-0xFF only with I/O strobe alone.
// - Byte DMA space maps eight 16K sectors contiguously over 128K.
// - Overlay space selects sector n at 0x0000-0x3FFF when page equals n.
// - External chip select low for I/O addresses 0x200-0x207 only.
// - Control block spans 256 locations, 27 hold registers.
// - Reset clears every control register to zero.
// - Pin input offsets return live pin levels; writes ignored.
// - Output latches drive pins in output mode and read back.
// - Direction bit 1 makes pin output, 0 input; readable.
// - Drive select registers pick open drain or slew; readable.
// - Input macrocell offsets return live cell state; writes ignored.
// - Enable-out offsets return driver enable state; writes ignored.
// - Offsets 20 and 21 read and load output macrocells.
// - Mask bit 1 blocks read and write of matching macrocell.
// - Offset C0 reports sector protection; writes ignored.
// - Offset C2 reads 1 when the device is secured.
// - Offset C7 enables test port pins and reads back.
// - Power management registers at B0 and B4 are read/write.
// - Page register at E0 is read/write and steers overlay decode.
module dmcsr_top (
  input  wire logic        mclk_i,         // 25 MHz clock
  input  wire logic        rst_i,          // Async reset, high
  input  wire logic        bus_io_n_i,     // I/O space strobe
  input  wire logic        bus_dm_n_i,     // Data overlay strobe
  input  wire logic        bus_bd_n_i,     // Byte DMA strobe
  input  wire logic        bus_wr_n_i,     // Write strobe
  input  wire logic        bus_rd_n_i,     // Read strobe
  input  wire logic [16:0] bus_addr_i,     // Host address
  input  wire logic [7:0]  bus_data_i,     // Host data, low byte
  output logic      [7:0]  data_o,         // Read data
  output logic             data_oe_o,      // Read data drive enable
  output logic             csiop_sel_o,    // Control block selected
  output logic             ext_cs_n_o,     // External peripheral select
  output logic      [7:0]  sector_sel_o,   // Flash sector selects
  input  wire logic [7:0]  port_b_pin_i,   // Port B pin levels
  input  wire logic [7:0]  port_c_pin_i,   // Port C pin levels
  input  wire logic [7:0]  port_d_pin_i,   // Port D pin levels
  output logic      [7:0]  port_b_out_o,   // Port B output latch
  output logic      [7:0]  port_c_out_o,   // Port C output latch
  output logic      [7:0]  port_d_out_o,   // Port D output latch
  output logic      [7:0]  port_b_oe_o,    // Port B drive enable
  output logic      [7:0]  port_c_oe_o,    // Port C drive enable
  output logic      [7:0]  port_d_oe_o,    // Port D drive enable
  output logic      [7:0]  port_b_drive_o, // Port B drive type
  output logic      [7:0]  port_c_drive_o, // Port C drive type
  output logic      [7:0]  port_d_drive_o, // Port D drive type
  input  wire logic [7:0]  imc_b_i,        // Port B input macrocells
  input  wire logic [7:0]  imc_c_i,        // Port C input macrocells
  input  wire logic [7:0]  sector_prot_i,  // Sector protection setting
  input  wire logic        secure_i,       // Security bit
  output logic      [7:0]  omc_ab_o,       // Output_cells_bank_ab
  output logic      [7:0]  omc_bc_o,       // Output_cells_bank_bc
  output logic      [7:0]  pm0_o,          // Power management 0
  output logic      [7:0]  pm2_o,          // Power management 2
  output logic      [7:0]  jtag_en_o,      // Test port pin enable
  output logic      [7:0]  page_o          // Memory page
);

  localparam int SW = $bits(dmcsr_pkg::dmcsr_bus_t) + 24;

  // ==========================================================
  // Pin filtering: three stages, accept when stages two and three agree
  logic [SW-1:0]         raw;
  logic [SW-1:0]         s1_r;
  logic [SW-1:0]         s2_r;
  logic [SW-1:0]         s3_r;
  logic [SW-1:0]         flt_r;
  logic [SW-1:0]         flt_nxt;
  logic [SW-1:0]         flt_rst;

  assign raw     = {bus_io_n_i, bus_dm_n_i, bus_bd_n_i, bus_wr_n_i, bus_rd_n_i,
                    bus_addr_i, bus_data_i, port_b_pin_i, port_c_pin_i, port_d_pin_i};
  assign flt_rst = {dmcsr_pkg::BUS_IDLE, 24'h00_0000};
  assign flt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r  <= flt_rst;
      s2_r  <= flt_rst;
      s3_r  <= flt_rst;
      flt_r <= flt_rst;
    end else begin
      s1_r  <= raw;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  dmcsr_pkg::dmcsr_bus_t bus;
  dmcsr_pkg::dmcsr_bus_t bus_q_r;
  logic [2:0][7:0]       pin;
  logic [2:0][7:0]       pin_q_r;

  assign bus = flt_r[SW-1:24];
  assign pin = flt_r[23:0];

  // Delayed copy lines up with the registered decode
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_q_r <= dmcsr_pkg::BUS_IDLE;
      pin_q_r <= 24'h00_0000;
    end else begin
      bus_q_r <= bus;
      pin_q_r <= pin;
    end
  end

  // ==========================================================
  // Decode
  dmcsr_pkg::dmcsr_dec_t dec;
  logic [7:0]            page_r;

  dmcsr_decode u_decode (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .bus_i  (bus),
    .page_i (page_r),
    .dec_o  (dec)
  );

  assign csiop_sel_o  = dec.csiop;
  assign ext_cs_n_o   = dec.ext_cs_n;
  assign sector_sel_o = dec.sector;

  // ==========================================================
  // Register write strobe
  logic       wr_rise;
  logic       rd_act;
  logic [7:0] ofs;
  logic [7:0] wdat;

  assign wr_rise = dec.csiop && !bus_q_r.wr_n && bus.wr_n;
  assign rd_act  = dec.csiop && !bus_q_r.rd_n;
  assign ofs     = bus_q_r.addr[7:0];
  assign wdat    = bus_q_r.data;

  // ==========================================================
  // Port registers
  logic [2:0][7:0] out_r;
  logic [2:0][7:0] dir_r;
  logic [2:0][7:0] drv_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_r <= '0;
    end else if (wr_rise) begin
      case (ofs)
        dmcsr_pkg::OFS_B_OUT: out_r[0] <= wdat;
        dmcsr_pkg::OFS_C_OUT: out_r[1] <= wdat;
        dmcsr_pkg::OFS_D_OUT: out_r[2] <= wdat;
        default: out_r <= out_r;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_r <= '0;
    end else if (wr_rise) begin
      case (ofs)
        dmcsr_pkg::OFS_B_DIR: dir_r[0] <= wdat;
        dmcsr_pkg::OFS_C_DIR: dir_r[1] <= wdat;
        dmcsr_pkg::OFS_D_DIR: dir_r[2] <= wdat;
        default: dir_r <= dir_r;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      drv_r <= '0;
    end else if (wr_rise) begin
      case (ofs)
        dmcsr_pkg::OFS_B_DRV: drv_r[0] <= wdat;
        dmcsr_pkg::OFS_C_DRV: drv_r[1] <= wdat;
        dmcsr_pkg::OFS_D_DRV: drv_r[2] <= wdat;
        default: drv_r <= drv_r;
      endcase
    end
  end

  assign port_b_out_o   = out_r[0];
  assign port_c_out_o   = out_r[1];
  assign port_d_out_o   = out_r[2];
  assign port_b_oe_o    = dir_r[0];
  assign port_c_oe_o    = dir_r[1];
  assign port_d_oe_o    = dir_r[2];
  assign port_b_drive_o = drv_r[0];
  assign port_c_drive_o = drv_r[1];
  assign port_d_drive_o = drv_r[2];

  // ==========================================================
  // Output macrocells and masks
  logic [7:0] omc_ab_r;
  logic [7:0] omc_bc_r;
  logic [7:0] msk_ab_r;
  logic [7:0] msk_bc_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      msk_ab_r <= dmcsr_pkg::REG_RESET;
      msk_bc_r <= dmcsr_pkg::REG_RESET;
    end else if (wr_rise && ofs == dmcsr_pkg::OFS_MSK_AB) begin
      msk_ab_r <= wdat;
    end else if (wr_rise && ofs == dmcsr_pkg::OFS_MSK_BC) begin
      msk_bc_r <= wdat;
    end
  end

  // Masked cells keep their value
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      omc_ab_r <= dmcsr_pkg::REG_RESET;
      omc_bc_r <= dmcsr_pkg::REG_RESET;
    end else if (wr_rise && ofs == dmcsr_pkg::OFS_OMC_AB) begin
      omc_ab_r <= (omc_ab_r & msk_ab_r) | (wdat & ~msk_ab_r);
    end else if (wr_rise && ofs == dmcsr_pkg::OFS_OMC_BC) begin
      omc_bc_r <= (omc_bc_r & msk_bc_r) | (wdat & ~msk_bc_r);
    end
  end

  assign omc_ab_o = omc_ab_r;
  assign omc_bc_o = omc_bc_r;

  // ==========================================================
  // Power, test port and page
  logic [7:0] pm0_r;
  logic [7:0] pm2_r;
  logic [7:0] jtag_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pm0_r  <= dmcsr_pkg::REG_RESET;
      pm2_r  <= dmcsr_pkg::REG_RESET;
      jtag_r <= dmcsr_pkg::REG_RESET;
      page_r <= dmcsr_pkg::REG_RESET;
    end else if (wr_rise) begin
      case (ofs)
        dmcsr_pkg::OFS_PM0:  pm0_r  <= wdat;
        dmcsr_pkg::OFS_PM2:  pm2_r  <= wdat;
        dmcsr_pkg::OFS_JTAG: jtag_r <= wdat;
        dmcsr_pkg::OFS_PAGE: page_r <= wdat;
        default: page_r <= page_r;
      endcase
    end
  end

  assign pm0_o     = pm0_r;
  assign pm2_o     = pm2_r;
  assign jtag_en_o = jtag_r;
  assign page_o    = page_r;

  // ==========================================================
  // Read path; unused and read-only targets ignore writes
  logic [7:0] rd_nxt;
  logic [7:0] rdata_r;
  logic       rd_oe_r;

  always_comb begin
    case (ofs)
      dmcsr_pkg::OFS_B_IN:   rd_nxt = pin_q_r[2];
      dmcsr_pkg::OFS_C_IN:   rd_nxt = pin_q_r[1];
      dmcsr_pkg::OFS_D_IN:   rd_nxt = pin_q_r[0];
      dmcsr_pkg::OFS_B_OUT:  rd_nxt = out_r[0];
      dmcsr_pkg::OFS_C_OUT:  rd_nxt = out_r[1];
      dmcsr_pkg::OFS_D_OUT:  rd_nxt = out_r[2];
      dmcsr_pkg::OFS_B_DIR:  rd_nxt = dir_r[0];
      dmcsr_pkg::OFS_C_DIR:  rd_nxt = dir_r[1];
      dmcsr_pkg::OFS_D_DIR:  rd_nxt = dir_r[2];
      dmcsr_pkg::OFS_B_DRV:  rd_nxt = drv_r[0];
      dmcsr_pkg::OFS_C_DRV:  rd_nxt = drv_r[1];
      dmcsr_pkg::OFS_D_DRV:  rd_nxt = drv_r[2];
      dmcsr_pkg::OFS_B_IMC:  rd_nxt = imc_b_i;
      dmcsr_pkg::OFS_C_IMC:  rd_nxt = imc_c_i;
      dmcsr_pkg::OFS_B_OEN:  rd_nxt = dir_r[0];
      dmcsr_pkg::OFS_C_OEN:  rd_nxt = dir_r[1];
      dmcsr_pkg::OFS_D_OEN:  rd_nxt = dir_r[2];
      dmcsr_pkg::OFS_OMC_AB: rd_nxt = omc_ab_r & ~msk_ab_r;
      dmcsr_pkg::OFS_OMC_BC: rd_nxt = omc_bc_r & ~msk_bc_r;
      dmcsr_pkg::OFS_MSK_AB: rd_nxt = msk_ab_r;
      dmcsr_pkg::OFS_MSK_BC: rd_nxt = msk_bc_r;
      dmcsr_pkg::OFS_PM0:    rd_nxt = pm0_r;
      dmcsr_pkg::OFS_PM2:    rd_nxt = pm2_r;
      dmcsr_pkg::OFS_PROT:   rd_nxt = sector_prot_i;
      dmcsr_pkg::OFS_SECUR:  rd_nxt = {7'h00, secure_i};
      dmcsr_pkg::OFS_JTAG:   rd_nxt = jtag_r;
      dmcsr_pkg::OFS_PAGE:   rd_nxt = page_r;
      default:               rd_nxt = dmcsr_pkg::REG_RESET;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= dmcsr_pkg::REG_RESET;
      rd_oe_r <= 1'b0;
    end else begin
      rdata_r <= rd_act ? rd_nxt : dmcsr_pkg::REG_RESET;
      rd_oe_r <= rd_act;
    end
  end

  assign data_o    = rdata_r;
  assign data_oe_o = rd_oe_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr(logic [7:0] o);
    wr_rise && ofs == o;
  endsequence

  page_write_a: assert property (s_wr(dmcsr_pkg::OFS_PAGE) |=> page_o == $past(wdat))
    else $error("page register not loaded");
  latch_write_a: assert property (s_wr(dmcsr_pkg::OFS_C_OUT) |=> port_c_out_o == $past(wdat))
    else $error("port c latch not loaded");
  dir_oe_a: assert property (s_wr(dmcsr_pkg::OFS_B_DIR) |=> port_b_oe_o == $past(wdat))
    else $error("port b direction not applied");
  omc_mask_a: assert property (s_wr(dmcsr_pkg::OFS_OMC_AB)
    |=> ((omc_ab_o ^ $past(omc_ab_r)) & $past(msk_ab_r)) == 8'h00)
    else $error("masked macrocell changed");
  pin_read_a: assert property (rd_act && ofs == dmcsr_pkg::OFS_D_IN
    |=> data_o == $past(pin_q_r[0]) && data_oe_o)
    else $error("pin level not returned");
  secure_read_a: assert property (rd_act && ofs == dmcsr_pkg::OFS_SECUR
    |=> data_o == {7'h00, $past(secure_i)})
    else $error("security bit not returned");
  jtag_hold_a: assert property (!(s_wr(dmcsr_pkg::OFS_JTAG)) |=> $stable(jtag_en_o))
    else $error("test port enable changed without write");
  pm_write_a: assert property (s_wr(dmcsr_pkg::OFS_PM2) |=> pm2_o == $past(wdat))
    else $error("power management 2 not loaded");

endmodule : dmcsr_top

// file: src/dmcsr_pkg.sv
// Purpose: Shared types and constants of the DSP memory decode and control bank.
// Assumes: Byte-wide host bus, 17-bit address, active-low space strobes.
// Notes:   Offsets are low-byte addresses inside the control block.
package dmcsr_pkg;

  // ==========================================================
  // Address map
  localparam int              ADDR_W     = 17;
  localparam int              NSECT      = 8;
  localparam int              SECT_SHIFT = 14;
  localparam logic [16:0]     CSIOP_LO   = 17'h0_0000;
  localparam logic [16:0]     CSIOP_HI   = 17'h0_00FF;
  localparam logic [16:0]     EXT_LO     = 17'h0_0200;
  localparam logic [16:0]     EXT_HI     = 17'h0_0207;
  localparam logic [16:0]     SECT_SPAN  = 17'h0_3FFF;
  localparam logic [16:0]     BYTE_DMA_CHANNEL_HI    = 17'h1_FFFF;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_B_IN   = 8'h01;
  localparam logic [7:0] OFS_B_OUT  = 8'h05;
  localparam logic [7:0] OFS_B_DIR  = 8'h07;
  localparam logic [7:0] OFS_B_DRV  = 8'h09;
  localparam logic [7:0] OFS_B_IMC  = 8'h0B;
  localparam logic [7:0] OFS_B_OEN  = 8'h0D;
  localparam logic [7:0] OFS_C_IN   = 8'h10;
  localparam logic [7:0] OFS_D_IN   = 8'h11;
  localparam logic [7:0] OFS_C_OUT  = 8'h12;
  localparam logic [7:0] OFS_D_OUT  = 8'h13;
  localparam logic [7:0] OFS_C_DIR  = 8'h14;
  localparam logic [7:0] OFS_D_DIR  = 8'h15;
  localparam logic [7:0] OFS_C_DRV  = 8'h16;
  localparam logic [7:0] OFS_D_DRV  = 8'h17;
  localparam logic [7:0] OFS_C_IMC  = 8'h18;
  localparam logic [7:0] OFS_C_OEN  = 8'h1A;
  localparam logic [7:0] OFS_D_OEN  = 8'h1B;
  localparam logic [7:0] OFS_OMC_AB = 8'h20;
  localparam logic [7:0] OFS_OMC_BC = 8'h21;
  localparam logic [7:0] OFS_MSK_AB = 8'h22;
  localparam logic [7:0] OFS_MSK_BC = 8'h23;
  localparam logic [7:0] OFS_PM0    = 8'hB0;
  localparam logic [7:0] OFS_PM2    = 8'hB4;
  localparam logic [7:0] OFS_PROT   = 8'hC0;
  localparam logic [7:0] OFS_SECUR  = 8'hC2;
  localparam logic [7:0] OFS_JTAG   = 8'hC7;
  localparam logic [7:0] OFS_PAGE   = 8'hE0;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        io_n;
    logic        dm_n;
    logic        bd_n;
    logic        wr_n;
    logic        rd_n;
    logic [16:0] addr;
    logic [7:0]  data;
  } dmcsr_bus_t;

  typedef struct packed {
    logic       csiop;
    logic       ext_cs_n;
    logic [7:0] sector;
  } dmcsr_dec_t;

  localparam dmcsr_bus_t BUS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 17'h0_0000, 8'h00};
  localparam dmcsr_dec_t DEC_IDLE = '{1'b0, 1'b1, 8'h00};

endpackage : dmcsr_pkg

// file: src/dmcsr_decode.sv
// Purpose: Registered address decoder for control block, chip select, sectors.
// Assumes: Bus input already filtered onto mclk_i.
// Notes:   Outputs lag the bus by one clock.
module dmcsr_decode (
  input  wire logic                 mclk_i,  // System clock
  input  wire logic                 rst_i,   // Async reset, high
  input  wire dmcsr_pkg::dmcsr_bus_t bus_i,  // Filtered host bus
  input  wire logic [7:0]           page_i,  // Memory page register
  output dmcsr_pkg::dmcsr_dec_t     dec_o    // Registered selects
);

  // ==========================================================
  // Strobe qualification
  logic                  io_only;
  logic                  dm_only;
  logic                  bd_only;
  dmcsr_pkg::dmcsr_dec_t dec_nxt;

  assign io_only = !bus_i.io_n && bus_i.dm_n && bus_i.bd_n;
  assign dm_only = bus_i.io_n && !bus_i.dm_n && bus_i.bd_n;
  assign bd_only = bus_i.io_n && bus_i.dm_n && !bus_i.bd_n;

  assign dec_nxt.csiop = io_only && bus_i.addr >= dmcsr_pkg::CSIOP_LO
                         && bus_i.addr <= dmcsr_pkg::CSIOP_HI;
  assign dec_nxt.ext_cs_n = !(io_only && bus_i.addr >= dmcsr_pkg::EXT_LO
                              && bus_i.addr <= dmcsr_pkg::EXT_HI);

  for (genvar n = 0; n < dmcsr_pkg::NSECT; n++) begin : g_sect
    assign dec_nxt.sector[n] =
      (bd_only && bus_i.addr <= dmcsr_pkg::BYTE_DMA_CHANNEL_HI
       && bus_i.addr[dmcsr_pkg::ADDR_W-1:dmcsr_pkg::SECT_SHIFT] == 3'(n))
      || (dm_only && bus_i.addr <= dmcsr_pkg::SECT_SPAN
          && page_i == 8'(n));
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dec_o <= dmcsr_pkg::DEC_IDLE;
    end else begin
      dec_o <= dec_nxt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  csiop_io_only_a: assert property (dec_o.csiop |-> $past(io_only)
    && $past(bus_i.addr) <= dmcsr_pkg::CSIOP_HI)
    else $error("control block selected outside io space");
  byte_dma_channel_sector_a: assert property (bd_only |=> dec_o.sector[$past(bus_i.addr[16:14])])
    else $error("byte dma sector not selected");
  overlay_page_a: assert property (dm_only && page_i > 8'h07 |=> dec_o.sector == 8'h00)
    else $error("sector selected for out of range page");
  ext_cs_a: assert property (io_only && bus_i.addr == dmcsr_pkg::EXT_LO |=> !dec_o.ext_cs_n)
    else $error("external chip select missing");
  one_strobe_a: assert property (!(io_only || dm_only || bd_only) |=> dec_o == dmcsr_pkg::DEC_IDLE)
    else $error("decode active without a single strobe");
  sector_onehot_a: assert property ($onehot0(dec_o.sector))
    else $error("more than one sector selected");

endmodule : dmcsr_decode

// file: sim/dmcsr_host_model.sv
// Purpose: Behavioural DSP host driving the space-strobed byte bus.
// Assumes: Signals change just after a rising edge of mclk_i and hold until sampled.
// Notes:   Released address and data lines show the inverse of their last value.
module dmcsr_host_model (
  input  wire logic        mclk_i,   // System clock
  input  wire logic [7:0]  rdata_i,  // Read data from the block
  output logic             io_n_o,   // I/O space strobe
  output logic             dm_n_o,   // Overlay space strobe
  output logic             bd_n_o,   // Byte DMA strobe
  output logic             wr_n_o,   // Write strobe
  output logic             rd_n_o,   // Read strobe
  output logic      [16:0] addr_o,   // Host address
  output logic      [7:0]  data_o    // Low data byte
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {io_n_o, dm_n_o, bd_n_o, wr_n_o, rd_n_o} = 5'h1F;
    addr_o = 17'h0_0000;
    data_o = 8'h00;
  end

  // ==========================================================
  // Bus cycles
  task automatic release_bus(); // All strobes return high together, then four idle clocks
    @(posedge mclk_i);
    {io_n_o, dm_n_o, bd_n_o, wr_n_o, rd_n_o} <= 5'h1F;
    addr_o <= ~addr_o;
    data_o <= ~data_o;
    repeat (4) @(posedge mclk_i);
  endtask : release_bus

  task automatic space(input logic [2:0] s, input logic [16:0] a); // s is io, dm, bd
    @(posedge mclk_i);
    {io_n_o, dm_n_o, bd_n_o} <= s;
    addr_o <= a;
  endtask : space

  task automatic wr_byte(input logic [7:0] ofs, input logic [7:0] d); // Byte only
    @(posedge mclk_i);
    io_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    addr_o <= {9'h000, ofs};
    data_o <= d;
    repeat (8) @(posedge mclk_i);
    wr_n_o <= 1'b1;
    repeat (6) @(posedge mclk_i);
    release_bus();
  endtask : wr_byte

  task automatic rd_byte(input logic [7:0] ofs, output logic [7:0] d);
    @(posedge mclk_i);
    io_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    addr_o <= {9'h000, ofs};
    repeat (8) @(posedge mclk_i);
    d = rdata_i;
    release_bus();
  endtask : rd_byte
endmodule : dmcsr_host_model

// file: sim/dsp_memory_decode_and_csr_tb.sv
// Purpose: Self-checking bench for the decoder and control register bank.
// Assumes: Host model owns the bus; pin and macrocell inputs are static.
// Notes:   Read/write registers are first written with offset xor 8'h5A.
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module dsp_memory_decode_and_csr_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, io_n, dm_n, bd_n, wr_n, rd_n, csiop, ext_n, secure;
  logic [16:0] addr;
  logic [7:0]  wdata, rdata, sector, rd_v, b_out, c_oe, d_drv, omc_ab, pm2, jtag, page;
  logic [7:0]  pin_b, pin_c, pin_d, imc_b, imc_c, prot;
  int          cmp_count, miscompares;
  logic [7:0]  rw_ofs [17] = '{8'h05, 8'h07, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
                               8'h20, 8'h21, 8'h22, 8'h23, 8'hB0, 8'hB4, 8'hC7, 8'hE0};
  logic [7:0]  ro_ofs [10] = '{8'h01, 8'h10, 8'h11, 8'h0B, 8'h18, 8'hC0, 8'hC2, 8'h0D, 8'h1A,
                               8'h1B};
  logic [7:0]  ro_exp [10];

  dmcsr_top dmcsr_top_i (.mclk_i(mclk), .rst_i(rst), .bus_io_n_i(io_n), .bus_dm_n_i(dm_n),
    .bus_bd_n_i(bd_n), .bus_wr_n_i(wr_n), .bus_rd_n_i(rd_n), .bus_addr_i(addr),
    .bus_data_i(wdata), .data_o(rdata), .data_oe_o(), .csiop_sel_o(csiop), .ext_cs_n_o(ext_n),
    .sector_sel_o(sector), .port_b_pin_i(pin_b), .port_c_pin_i(pin_c), .port_d_pin_i(pin_d),
    .port_b_out_o(b_out), .port_c_out_o(), .port_d_out_o(), .port_b_oe_o(), .port_c_oe_o(c_oe),
    .port_d_oe_o(), .port_b_drive_o(), .port_c_drive_o(), .port_d_drive_o(d_drv),
    .imc_b_i(imc_b), .imc_c_i(imc_c), .sector_prot_i(prot), .secure_i(secure),
    .omc_ab_o(omc_ab), .omc_bc_o(), .pm0_o(), .pm2_o(pm2), .jtag_en_o(jtag), .page_o(page));

  dmcsr_host_model dmcsr_host_model_i (.mclk_i(mclk), .rdata_i(rdata), .io_n_o(io_n),
    .dm_n_o(dm_n), .bd_n_o(bd_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .addr_o(addr), .data_o(wdata));

  // ==========================================================
  // Helpers
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic dec(input logic [2:0] s, input logic [16:0] a, input logic [9:0] e);
    dmcsr_host_model_i.space(s, a);
    repeat (6) @(posedge mclk);
    `CHK({csiop, ext_n, sector}, e);
    dmcsr_host_model_i.release_bus();
  endtask : dec

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    repeat (10000) @(posedge mclk);
    miscompares++;
    end_sim();
  end

  // ==========================================================
  // Tests
  initial begin
    rst = 1'b1;
    {pin_b, pin_c, pin_d, imc_b, imc_c, prot, secure} = {48'h3CC3_9669_A581, 1'b1};
    ro_exp = '{pin_b, pin_c, pin_d, imc_b, imc_c, prot, 8'h01, 8'h5D, 8'h4E, 8'h4F};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    foreach (rw_ofs[i]) begin
      dmcsr_host_model_i.rd_byte(rw_ofs[i], rd_v);
      `CHK(rd_v, dmcsr_pkg::REG_RESET);
    end
    foreach (rw_ofs[i]) begin
      dmcsr_host_model_i.wr_byte(rw_ofs[i], rw_ofs[i] ^ 8'h5A);
      dmcsr_host_model_i.rd_byte(rw_ofs[i], rd_v);
      `CHK(rd_v, rw_ofs[i] ^ 8'h5A);
    end
    `CHK({b_out, c_oe, d_drv}, 24'h5F_4E4D);
    `CHK({pm2, jtag, page}, 24'hEE_9DBA);
    foreach (ro_ofs[i]) begin
      dmcsr_host_model_i.wr_byte(ro_ofs[i], 8'hFF);
      dmcsr_host_model_i.rd_byte(ro_ofs[i], rd_v);
      `CHK(rd_v, ro_exp[i]);
    end
    foreach (ro_exp[i]) begin
      dmcsr_host_model_i.rd_byte(8'h24 + 8'(i * 8), rd_v); // Unused offsets only
      `CHK(rd_v, 8'h00);
    end
    dmcsr_host_model_i.wr_byte(8'h22, 8'h0F);
    dmcsr_host_model_i.wr_byte(8'h20, 8'hFF);
    `CHK(omc_ab, 8'hFA);
    dmcsr_host_model_i.rd_byte(8'h20, rd_v);
    `CHK(rd_v, 8'hF0);
    dec(3'b011, 17'h0_00FF, 10'h300);
    dec(3'b011, 17'h0_0100, 10'h100);
    dec(3'b001, 17'h0_0000, 10'h100);
    dec(3'b011, 17'h0_0200, 10'h000);
    dec(3'b011, 17'h0_0207, 10'h000);
    dec(3'b011, 17'h0_0208, 10'h100);
    dec(3'b010, 17'h0_0204, 10'h100);
    dec(3'b111, 17'h0_0000, 10'h100);
    for (int n = 0; n < 8; n++) begin
      dec(3'b110, 17'(n << 14), {2'b01, 8'h01 << n});
      dec(3'b110, 17'(n << 14) + 17'h0_3FFF, {2'b01, 8'h01 << n});
      dmcsr_host_model_i.wr_byte(8'hE0, 8'(n));
      dec(3'b101, 17'h0_3FFF, {2'b01, 8'h01 << n});
      dec(3'b101, 17'h0_4000, 10'h100);
    end
    dmcsr_host_model_i.wr_byte(8'hE0, 8'h08);
    dec(3'b101, 17'h0_0000, 10'h100);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    `CHK({b_out, omc_ab, page}, 24'h00_0000);
    end_sim();
  end
endmodule : dsp_memory_decode_and_csr_tb
